// [src/sbm_ram.sv]
// Purpose: byte-masked synchronous ram with packed halves and address hold
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: output registers alone see the asynchronous clear
`timescale 1ns/1ps
`default_nettype none
module sbm_ram (
  input  wire logic                   hclk,      // clock
  input  wire logic                   hresetn,   // chip-wide clear, low
  input  wire logic                   hsel,      // ahb select
  input  wire logic [31:0]            haddr,     // ahb address
  input  wire logic [1:0]             htrans,    // ahb transfer type
  input  wire logic                   hwrite,    // ahb write
  input  wire logic [2:0]             hsize,     // ahb size
  input  wire logic [31:0]            hwdata,    // ahb write data
  input  wire logic                   hready,    // ahb ready in
  output logic                        hreadyout, // ahb ready out
  output logic                        hresp,     // ahb response
  output logic      [31:0]            hrdata,    // ahb read data
  input  wire logic                   block_ce,  // block clock enable
  input  wire logic                   out_aclr,  // output clear, high
  input  wire logic [sbm_pkg::AW-1:0] a_addr,    // port a address
  input  wire logic [sbm_pkg::DW-1:0] a_din,     // port a write data
  input  wire logic                   a_wren,    // port a write enable
  input  wire logic                   a_hold,    // port a address hold
  input  wire logic [sbm_pkg::AW-1:0] b_addr,    // port b address
  input  wire logic [sbm_pkg::DW-1:0] b_din,     // port b write data
  input  wire logic                   b_wren,    // port b write enable
  input  wire logic                   b_hold,    // port b address hold
  input  wire logic [3:0]             lane_mask, // byte lane mask
  output logic      [sbm_pkg::DW-1:0] q_a,       // port a read data
  output logic      [sbm_pkg::DW-1:0] q_b        // port b read data
);

  // ******************************
  // declarations
  // ******************************
  logic [sbm_pkg::DW-1:0] mem [0:sbm_pkg::WORDS-1];

  logic [12:0]            cfg_q;
  logic [31:0]            stat;
  logic [31:0]            hrdata_q;
  logic                   hreadyout_q;
  logic                   hresp_q;
  logic                   wr_pend_q;
  logic [7:0]             wa_q;
  logic                   ahb_go;

  logic                   pack_on;
  logic                   pipe_a;
  logic                   pipe_b;
  logic                   mask_use;
  logic                   hold_use;

  logic [sbm_pkg::IW-1:0] a_idx;
  logic [sbm_pkg::IW-1:0] b_idx;
  logic [sbm_pkg::DW-1:0] a_bm;
  logic [sbm_pkg::DW-1:0] b_bm;
  logic [sbm_pkg::DW-1:0] a_wp;
  logic [sbm_pkg::DW-1:0] b_wp;
  logic [sbm_pkg::DW-1:0] a_wm;
  logic [sbm_pkg::DW-1:0] b_wm;
  logic [5:0]             a_off;
  logic [5:0]             b_off;
  logic [sbm_pkg::AW-1:0] a_addr_q;
  logic [3:0]             a_lanes_q;
  logic                   a_wren_q;

  logic                   b_wr;
  logic [sbm_pkg::DW-1:0] word_a;
  logic [sbm_pkg::DW-1:0] word_b;
  logic [sbm_pkg::DW-1:0] nw_a;
  logic [sbm_pkg::DW-1:0] nw_b;
  logic [sbm_pkg::DW-1:0] rd_a_d;
  logic [sbm_pkg::DW-1:0] rd_b_d;
  logic [sbm_pkg::DW-1:0] rd_a_q;
  logic [sbm_pkg::DW-1:0] rd_b_q;
  logic [sbm_pkg::DW-1:0] q_a_q;
  logic [sbm_pkg::DW-1:0] q_b_q;
  logic                   out_rst_n;

  // ******************************
  // configuration decode
  // ******************************
  assign pack_on  = cfg_q[sbm_pkg::CFG_PACK];
  assign pipe_a   = cfg_q[sbm_pkg::CFG_PIPEA];
  assign pipe_b   = cfg_q[sbm_pkg::CFG_PIPEB];
  assign mask_use = cfg_q[sbm_pkg::CFG_MASKU];
  assign hold_use = cfg_q[sbm_pkg::CFG_HOLDU];

  // ******************************
  // ahb-lite slave
  // ******************************
  assign ahb_go = hsel && htrans[1] && hready;

  always_comb begin
    stat = '0;
    stat[sbm_pkg::ST_ADDR +: sbm_pkg::AW] = a_addr_q;
    stat[sbm_pkg::ST_MASK +: 4]           = a_lanes_q;
    stat[sbm_pkg::ST_WREN]                = a_wren_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h00;
    end else begin
      wr_pend_q <= ahb_go && hwrite && (hsize == 3'h2);
      wa_q      <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= sbm_pkg::CFG_RST;
    end else if (wr_pend_q && wa_q == sbm_pkg::REG_CFG) begin
      cfg_q <= hwdata[sbm_pkg::CFG_BITS-1:0];
    end
  end

  // a read right behind a config write sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (ahb_go && !hwrite) begin
      if (haddr[7:0] == sbm_pkg::REG_CFG) begin
        if (wr_pend_q && wa_q == sbm_pkg::REG_CFG) begin
          hrdata_q <= {19'h00000, hwdata[sbm_pkg::CFG_BITS-1:0]};
        end else begin
          hrdata_q <= {19'h00000, cfg_q};
        end
      end else if (haddr[7:0] == sbm_pkg::REG_STAT) begin
        hrdata_q <= stat;
      end else begin
        hrdata_q <= 32'h00000000;
      end
    end
  end

  // never stalls and never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;

  // ******************************
  // ports
  // ******************************
  sbm_port u_port_a (
    .hclk     (hclk),
    .ce       (block_ce),
    .addr_in  (a_addr),
    .din      (a_din),
    .wren     (a_wren),
    .lanes    (lane_mask),
    .hold     (a_hold),
    .code     (cfg_q[sbm_pkg::CFG_WA +: 4]),
    .mask_use (mask_use),
    .hold_use (hold_use),
    .pack_on  (pack_on),
    .upper    (1'b0),
    .idx      (a_idx),
    .bmask    (a_bm),
    .wpos     (a_wp),
    .wmask    (a_wm),
    .off      (a_off),
    .addr_q   (a_addr_q),
    .lanes_q  (a_lanes_q),
    .wren_q   (a_wren_q)
  );

  sbm_port u_port_b (
    .hclk     (hclk),
    .ce       (block_ce),
    .addr_in  (b_addr),
    .din      (b_din),
    .wren     (b_wren),
    .lanes    (lane_mask),
    .hold     (b_hold),
    .code     (cfg_q[sbm_pkg::CFG_WB +: 4]),
    .mask_use (mask_use),
    .hold_use (hold_use),
    .pack_on  (pack_on),
    .upper    (1'b1),
    .idx      (b_idx),
    .bmask    (b_bm),
    .wpos     (b_wp),
    .wmask    (b_wm),
    .off      (b_off),
    .addr_q   (),
    .lanes_q  (),
    .wren_q   ()
  );

  // ******************************
  // array and write-through
  // ******************************
  // port b exists only in packed use, so the halves never collide
  assign b_wr   = b_wren && pack_on;
  assign word_a = mem[a_idx];
  assign word_b = mem[b_idx];
  assign nw_a   = a_wren ? ((word_a & ~a_bm) | (a_wp & a_bm)) : word_a;
  assign nw_b   = b_wr ? ((word_b & ~b_bm) | (b_wp & b_bm)) : word_b;
  // masked lanes show the stored bits, which callers must not trust
  assign rd_a_d = (nw_a >> a_off) & a_wm;
  assign rd_b_d = (nw_b >> b_off) & b_wm;

  always_ff @(posedge hclk) begin
    if (block_ce) begin
      if (a_wren) begin
        mem[a_idx] <= nw_a;
      end
      if (b_wr) begin
        mem[b_idx] <= nw_b;
      end
    end
  end

  // ******************************
  // output registers
  // ******************************
  // gated reset: the clear acts at once and never touches input registers
  assign out_rst_n = hresetn && !out_aclr;

  always_ff @(posedge hclk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      rd_a_q <= '0;
      q_a_q  <= '0;
    end else if (block_ce) begin
      rd_a_q <= rd_a_d;
      q_a_q  <= pipe_a ? rd_a_q : rd_a_d;
    end
  end

  always_ff @(posedge hclk or negedge out_rst_n) begin
    if (!out_rst_n) begin
      rd_b_q <= '0;
      q_b_q  <= '0;
    end else if (block_ce && pack_on) begin
      rd_b_q <= rd_b_d;
      q_b_q  <= pipe_b ? rd_b_q : rd_b_d;
    end
  end

  assign q_a = q_a_q;
  assign q_b = q_b_q;

  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic                   chk_v_q;
  logic [sbm_pkg::IW-1:0] chk_i_q;
  logic [sbm_pkg::DW-1:0] chk_m_q;
  logic [sbm_pkg::DW-1:0] chk_o_q;
  logic [sbm_pkg::DW-1:0] chk_n_q;
  logic [3:0]             code_a;
  logic                   w8_full;

  assign code_a  = cfg_q[sbm_pkg::CFG_WA +: 4];
  assign w8_full = (code_a == sbm_pkg::W8) && !mask_use && !pack_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_v_q <= 1'b0;
    end else begin
      chk_v_q <= block_ce && a_wren;
    end
  end

  always_ff @(posedge hclk) begin
    chk_i_q <= a_idx;
    chk_m_q <= a_bm;
    chk_o_q <= word_a;
    chk_n_q <= a_wp;
  end

  // case equality: rows never written before still hold unloaded bits
  a_lane_keep: assert property (
    chk_v_q |-> (mem[chk_i_q] & ~chk_m_q) === (chk_o_q & ~chk_m_q))
    else $error("masked lane changed on write");

  a_lane_store: assert property (
    chk_v_q |-> (mem[chk_i_q] & chk_m_q) == (chk_n_q & chk_m_q))
    else $error("enabled lane not stored");

  a_lane_map32: assert property (
    (code_a == sbm_pkg::W32) && mask_use && !pack_on && lane_mask == 4'h5
    |-> a_bm == 36'h000ff00ff)
    else $error("32-bit lane map wrong");

  a_flow_write: assert property (
    block_ce && a_wren && !pipe_a && w8_full
    |=> out_aclr || q_a_q == ($past(a_din) & 36'h0000000ff))
    else $error("flow-through write data not on output");

  a_pipe_write: assert property (
    block_ce && a_wren && pipe_a && w8_full ##1 block_ce && !out_aclr
    |=> out_aclr || q_a_q == ($past(a_din, 2) & 36'h0000000ff))
    else $error("pipelined write data late or wrong");

  a_ce_freeze: assert property (
    !block_ce |=> out_aclr || ($stable(q_a_q) && $stable(q_b_q)))
    else $error("output moved without clock enable");

  a_out_clear: assert property (
    out_aclr |-> q_a_q == '0 && q_b_q == '0)
    else $error("output not cleared");

  a_addr_hold: assert property (
    block_ce && hold_use && a_hold ##1 block_ce && hold_use && a_hold
    && $stable(cfg_q) |-> a_idx == $past(a_idx) && a_off == $past(a_off))
    else $error("held address moved");

  a_pack_split: assert property (
    pack_on |-> !a_idx[6] && b_idx[6])
    else $error("packed halves overlap");

  a_pack_lanes: assert property (
    pack_on && mask_use && lane_mask[3:2] == 2'b00 |-> b_bm == '0)
    else $error("port b ignores its lane bits");

  c_sparse_mask: cover property (block_ce && a_wren && mask_use && lane_mask == 4'h5);
  c_hold_run:    cover property (block_ce && hold_use && a_hold [*3]);
  c_packed_both: cover property (block_ce && pack_on && a_wren && b_wren);

endmodule : sbm_ram
`default_nettype wire

// [src/sbm_pkg.sv]
// Purpose: shared constants for the byte-masked synchronous ram
// Assumes: one 10 MHz clock, registers reached over AHB-Lite
// Notes: width codes select one of nine array shapes
`default_nettype none
package sbm_pkg;

  localparam int AW    = 12;
  localparam int DW    = 36;
  localparam int IW    = 7;
  localparam int WORDS = 128;

  // width codes
  localparam logic [3:0] W1  = 4'h0;
  localparam logic [3:0] W2  = 4'h1;
  localparam logic [3:0] W4  = 4'h2;
  localparam logic [3:0] W8  = 4'h3;
  localparam logic [3:0] W9  = 4'h4;
  localparam logic [3:0] W16 = 4'h5;
  localparam logic [3:0] W18 = 4'h6;
  localparam logic [3:0] W32 = 4'h7;
  localparam logic [3:0] W36 = 4'h8;

  // register map and fields
  localparam logic [7:0]  REG_CFG   = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam int          CFG_WA    = 0;
  localparam int          CFG_WB    = 4;
  localparam int          CFG_PACK  = 8;
  localparam int          CFG_PIPEA = 9;
  localparam int          CFG_PIPEB = 10;
  localparam int          CFG_MASKU = 11;
  localparam int          CFG_HOLDU = 12;
  localparam int          CFG_BITS  = 13;
  localparam logic [12:0] CFG_RST   = 13'h0068;
  localparam int          ST_ADDR   = 0;
  localparam int          ST_MASK   = 12;
  localparam int          ST_WREN   = 16;

  // words per 36-bit row, as a shift; illegal codes act as W1
  function automatic logic [2:0] shift_of(input logic [3:0] c);
    case (c)
      W2:       shift_of = 3'h4;
      W4:       shift_of = 3'h3;
      W8, W9:   shift_of = 3'h2;
      W16, W18: shift_of = 3'h1;
      W32, W36: shift_of = 3'h0;
      default:  shift_of = 3'h5;
    endcase
  endfunction : shift_of

  function automatic logic [5:0] width_of(input logic [3:0] c);
    case (c)
      W2:      width_of = 6'h02;
      W4:      width_of = 6'h04;
      W8:      width_of = 6'h08;
      W9:      width_of = 6'h09;
      W16:     width_of = 6'h10;
      W18:     width_of = 6'h12;
      W32:     width_of = 6'h20;
      W36:     width_of = 6'h24;
      default: width_of = 6'h01;
    endcase
  endfunction : width_of

  function automatic logic par_of(input logic [3:0] c);
    par_of = (c == W9) || (c == W18) || (c == W36);
  endfunction : par_of

endpackage : sbm_pkg
`default_nettype wire

// [src/sbm_port.sv]
// Purpose: input capture and byte-lane mapping for one ram port
// Assumes: every register here is gated by the block clock enable
// Notes: input registers carry no clear, so they hold x until loaded
`timescale 1ns/1ps
`default_nettype none
module sbm_port (
  input  wire logic                   hclk,     // clock
  input  wire logic                   ce,       // block clock enable
  input  wire logic [sbm_pkg::AW-1:0] addr_in,  // raw address
  input  wire logic [sbm_pkg::DW-1:0] din,      // raw write data
  input  wire logic                   wren,     // write enable
  input  wire logic [3:0]             lanes,    // lane mask
  input  wire logic                   hold,     // address hold
  input  wire logic [3:0]             code,     // width code
  input  wire logic                   mask_use, // lane mask honoured
  input  wire logic                   hold_use, // hold honoured
  input  wire logic                   pack_on,  // half-block mode
  input  wire logic                   upper,    // port owns upper half
  output logic      [sbm_pkg::IW-1:0] idx,      // row index
  output logic      [sbm_pkg::DW-1:0] bmask,    // bits to write
  output logic      [sbm_pkg::DW-1:0] wpos,     // data placed in row
  output logic      [sbm_pkg::DW-1:0] wmask,    // datum width mask
  output logic      [5:0]             off,      // datum bit offset
  output logic      [sbm_pkg::AW-1:0] addr_q,   // captured address
  output logic      [3:0]             lanes_q,  // captured lane mask
  output logic                        wren_q    // captured write enable
);

  logic [3:0]             code_e;
  logic [2:0]             sh;
  logic [5:0]             w;
  logic                   par;
  logic [sbm_pkg::AW-1:0] addr_d;
  logic [sbm_pkg::AW-1:0] row;
  logic [sbm_pkg::AW-1:0] slot;
  logic [3:0]             sel;
  int                     ln;

  // ******************************
  // input registers
  // ******************************
  assign addr_d = (hold_use && hold) ? addr_q : addr_in;
  // hold feeds the register back to itself
  always_ff @(posedge hclk) begin
    if (ce) begin
      addr_q  <= addr_d;
      lanes_q <= lanes;
      wren_q  <= wren;
    end
  end

  // ******************************
  // shape and lane mapping
  // ******************************
  assign code_e = (pack_on && code > sbm_pkg::W18) ? sbm_pkg::W18 : code;
  assign sh     = sbm_pkg::shift_of(code_e);
  assign w      = sbm_pkg::width_of(code_e);
  assign par    = sbm_pkg::par_of(code_e);
  assign row    = addr_d >> sh;
  assign slot   = addr_d & ((12'h001 << sh) - 12'h001);
  assign off    = slot[5:0] * w;
  assign idx    = pack_on ? {upper, row[5:0]} : row[6:0];
  assign wmask  = (36'h000000001 << w) - 36'h000000001;
  assign wpos   = (din & wmask) << off;
  // unused mask reads as all high
  assign sel = !mask_use ? 4'hf :
               !pack_on  ? lanes :
               upper     ? {2'b00, lanes[3:2]} : {2'b00, lanes[1:0]};

  always_comb begin
    ln    = 0;
    bmask = '0;
    for (int j = 0; j < sbm_pkg::DW; j++) begin
      if (j < int'(w)) begin
        if (w <= 6'h09) begin
          ln = 0;
        end else if (par) begin
          ln = j / 9;
        end else begin
          ln = j / 8;
        end
        bmask[int'(off) + j] = sel[ln];
      end
    end
  end

endmodule : sbm_port
`default_nettype wire

// [testbench/sbm_user.sv]
// Purpose: user logic model that drives the ram ports
// Assumes: requests change just after a rising edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sbm_user (
  input  wire logic                   hclk,      // clock
  output logic      [sbm_pkg::AW-1:0] a_addr,    // port a address
  output logic      [sbm_pkg::DW-1:0] a_din,     // port a data
  output logic                        a_wren,    // port a write
  output logic                        a_hold,    // port a hold
  output logic      [sbm_pkg::AW-1:0] b_addr,    // port b address
  output logic      [sbm_pkg::DW-1:0] b_din,     // port b data
  output logic                        b_wren,    // port b write
  output logic                        b_hold,    // port b hold
  output logic      [3:0]             lane_mask  // lane mask
);
  initial begin
    {a_addr, a_din, a_wren, a_hold} = '0;
    {b_addr, b_din, b_wren, b_hold} = '0;
    lane_mask = 4'hf;
  end

  // one operation on port a (p=0) or b (p=1); the other port sees a read
  task automatic op(input logic p, input logic [11:0] a, input logic [35:0] d,
                    input logic we, input logic h, input logic [3:0] m);
    @(posedge hclk);
    lane_mask <= m;
    a_addr    <= a;
    b_addr    <= a;
    a_din     <= d;
    b_din     <= d;
    a_wren    <= we & ~p;
    b_wren    <= we & p;
    a_hold    <= h;
    b_hold    <= h;
    @(posedge hclk);
    a_wren    <= 1'b0;
    b_wren    <= 1'b0;
    a_din     <= ~a_din;
    b_din     <= ~b_din;
  endtask : op
endmodule : sbm_user
`default_nettype wire

// [testbench/sbm_ram_bench.sv]
// Purpose: self-checking bench for the byte-masked ram
// Assumes: zero wait-state register bus, one clock
// Notes: q is sampled 1 ns after the capturing edge
`timescale 1ns/1ps
`default_nettype none
module sbm_ram_bench;
  logic        hclk, hresetn, hsel, hwrite, block_ce, out_aclr, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] a_addr, b_addr;
  logic [35:0] a_din, b_din, q_a, q_b;
  logic        a_wren, a_hold, b_wren, b_hold;
  logic [3:0]  lane_mask;
  int          fail_count = 0;
  int          checks_done = 0;

  sbm_ram sbm_ram_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .block_ce(block_ce), .out_aclr(out_aclr), .a_addr(a_addr), .a_din(a_din),
    .a_wren(a_wren), .a_hold(a_hold), .b_addr(b_addr), .b_din(b_din),
    .b_wren(b_wren), .b_hold(b_hold), .lane_mask(lane_mask), .q_a(q_a), .q_b(q_b));

  sbm_user sbm_user_i (.hclk(hclk), .a_addr(a_addr), .a_din(a_din), .a_wren(a_wren),
    .a_hold(a_hold), .b_addr(b_addr), .b_din(b_din), .b_wren(b_wren),
    .b_hold(b_hold), .lane_mask(lane_mask));

  // ****************************************
  // clock, reset and watchdog
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    close_out();
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // single word transfer; read data lands in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic op(input logic p, input logic [11:0] a, input logic [35:0] d,
                    input logic we, input logic h, input logic [3:0] m);
    sbm_user_i.op(p, a, d, we, h, m);
    #1;
  endtask : op

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {hresetn, hsel, hwrite, out_aclr} = 4'h0;
    block_ce = 1'b1;
    {haddr, hwdata, htrans, hsize} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk("q_a reset", q_a, 36'h0);
    chk("q_b reset", q_b, 36'h0);
    ahb(1'b0, 8'h00, 32'h0);
    chk("cfg reset", {4'h0, r}, 36'h000000068);
    ahb(1'b0, 8'h08, 32'h0);
    chk("unmapped", {4'h0, r}, 36'h0);
    chk("hresp okay", {35'h0, hresp}, 36'h0);
    $display("test reset done");

    ahb(1'b1, 8'h00, 32'h00000807);
    op(1'b0, 12'h003, 36'h011223344, 1'b1, 1'b0, 4'hf);
    chk("x32 write through", q_a, 36'h011223344);
    op(1'b0, 12'h003, 36'h0aabbccdd, 1'b1, 1'b0, 4'h5);
    chk("x32 enabled lanes", q_a & 36'h000ff00ff, 36'h000bb00dd);
    op(1'b0, 12'h003, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("x32 masked", q_a, 36'h011bb33dd);
    ahb(1'b0, 8'h04, 32'h0);
    chk("stat capture", {19'h0, r[16:0]}, 36'h00000f003);
    $display("test x32 done");

    ahb(1'b1, 8'h00, 32'h00000808);
    op(1'b0, 12'h002, 36'hfffffffff, 1'b1, 1'b0, 4'hf);
    op(1'b0, 12'h002, 36'h0, 1'b1, 1'b0, 4'h8);
    op(1'b0, 12'h002, 36'h123456789, 1'b0, 1'b0, 4'hf);
    chk("x36 lane 3", q_a, 36'h007ffffff);
    op(1'b0, 12'h002, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("no write enable", q_a, 36'h007ffffff);
    $display("test x36 done");

    ahb(1'b1, 8'h00, 32'h00000803);
    op(1'b0, 12'h005, 36'h0000000ab, 1'b1, 1'b0, 4'hf);
    chk("x8 write", q_a, 36'h0000000ab);
    op(1'b0, 12'h005, 36'h000000055, 1'b1, 1'b0, 4'he);
    op(1'b0, 12'h005, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("x8 lane 0 enable", q_a, 36'h0000000ab);
    ahb(1'b1, 8'h00, 32'h00000003);
    op(1'b0, 12'h005, 36'h000000055, 1'b1, 1'b0, 4'h0);
    op(1'b0, 12'h005, 36'h0, 1'b0, 1'b0, 4'h0);
    chk("mask unused", q_a, 36'h000000055);
    $display("test x8 done");

    @(posedge hclk);
    block_ce <= 1'b0;
    op(1'b0, 12'h005, 36'h000000077, 1'b1, 1'b0, 4'hf);
    chk("ce low frozen", q_a, 36'h000000055);
    @(posedge hclk);
    block_ce <= 1'b1;
    op(1'b0, 12'h005, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("ce low no write", q_a, 36'h000000055);
    @(posedge hclk);
    out_aclr <= 1'b1;
    #1;
    chk("output clear", q_a, 36'h0);
    @(posedge hclk);
    out_aclr <= 1'b0;
    $display("test enable and clear done");

    ahb(1'b1, 8'h00, 32'h00000203);
    op(1'b0, 12'h009, 36'h00000003c, 1'b1, 1'b0, 4'hf);
    @(posedge hclk);
    #1;
    chk("pipelined write", q_a, 36'h00000003c);
    ahb(1'b1, 8'h00, 32'h00001003);
    op(1'b0, 12'h006, 36'h000000011, 1'b1, 1'b0, 4'hf);
    op(1'b0, 12'h007, 36'h000000022, 1'b1, 1'b1, 4'hf);
    op(1'b0, 12'h006, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("address hold", q_a, 36'h000000022);
    $display("test pipe and hold done");

    ahb(1'b1, 8'h00, 32'h00000966);
    op(1'b0, 12'h001, 36'h00003ffff, 1'b1, 1'b0, 4'h3);
    op(1'b1, 12'h001, 36'h00002aaaa, 1'b1, 1'b0, 4'hc);
    op(1'b1, 12'h001, 36'h0, 1'b1, 1'b0, 4'h8);
    op(1'b1, 12'h001, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("packed b lanes", q_b, 36'h0000000aa);
    op(1'b0, 12'h001, 36'h0, 1'b0, 1'b0, 4'hf);
    chk("packed a apart", q_a, 36'h00003ffff);
    $display("test packed done");
    close_out();
  end
endmodule : sbm_ram_bench
`default_nettype wire
